//--- verilog/gpp_port.sv
// gpp_port: eight pin gpio port with apb registers
// How it works
// - up to eight pins are controlled independently, the count set by N.
// - each pin has its own direction bit and all pins reset as inputs.
// - inputs raise interrupts on high, low, rising, falling or both edges.
// - each pin holds a drive of 2, 4 or 8 mA, reset to 2 mA.
// - slew limiting is offered only together with the 8 mA drive.
// - each pin may take a weak pull-up or pull-down, none after reset.
// - each pin may be open-drain, push-pull after reset.
// - pins go to software or a peripheral, software after reset.
// - data reads take address bits as a pin mask and zero the rest.
// - masked data writes change all selected pins at once, others kept.
// - mask bit n stands for pin n, pin zero in bit zero.
// - each pin's mode (sw in, sw out, hardware) reads back per pin.
// - per pin readback is addressed by a pin index from 0 to 7.
// - writing ones to the clear register drops pending pin interrupts.
// - an analog pad type exists beside push-pull and open-drain types.
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module gpp_port
    import gpp_pkg::*;
#(
    parameter int N = GPP_PINS // pins present
) (
    input wire logic clk_i, // 200 MHz system clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic [7:0] pin_i, // pad input levels
    output logic [7:0] pin_o, // pad output levels
    output logic [7:0] pin_oe_o, // pad output enables
    input wire logic [7:0] periph_o_i, // peripheral output data
    input wire logic [7:0] periph_oe_i, // peripheral output enables
    output logic [7:0] periph_i_o, // pin levels to peripherals
    output gpp_pkg::gpp_padctl_s padctl_o, // pad ring controls
    output logic irq_o // port interrupt, active high
);
    logic [7:0] pin_sync;
    logic [7:0] pin_prev_r, data_r, dir_r, afsel_r, sense_r, both_r;
    logic [7:0] event_r, imask_r, ris_r, iclr_set, padsel_r;
    logic [7:0] pres, hit, pad_we, od_vec;
    logic [2:0] idx_r;
    logic [7:0] mis, drv_d, drv_e;
    gpp_pad_s pad_rd;
    gpp_pad_s [7:0] pad_all;
    logic acc, wr, rd_phase, data_hit;
    logic [7:0] sel_mask;

    assign pres = 8'((9'h1 << N) - 9'h1); // pins really present
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign data_hit = (paddr[11:10] == GPP_DATA_BASE[11:10]);
    assign sel_mask = paddr[GPP_MASK_LSB +: 8] & pres;
    assign mis = ris_r & imask_r;

    // pad input levels feed the pin synchroniser
    gpp_sync #(.W(8)) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i(pin_i),
        .q_o(pin_sync)
    );

    // pad settings live in the small memory
    gpp_padmem #(.N(8)) u_pad (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .we_i(pad_we),
        .wdata_i(gpp_pad_s'({pwdata[4:3], pwdata[2:0]})),
        .raddr_i(idx_r),
        .rdata_o(pad_rd),
        .all_o(pad_all)
    );
    assign pad_we = (wr && paddr == GPP_PADCFG_OFF) ? (padsel_r & pres) : '0;

    // mode code for one pin
    function automatic logic [1:0] mode_of(input logic d, input logic a);
        if (a) mode_of = GPP_MODE_HW;
        else if (d) mode_of = GPP_MODE_SW_OUT;
        else mode_of = GPP_MODE_SW_IN;
    endfunction

    // interrupt type code for one pin
    function automatic logic [2:0] itype_of(input logic s, input logic b,
                                            input logic e);
        if (s) itype_of = e ? GPP_IT_HIGH : GPP_IT_LOW;
        else if (b) itype_of = GPP_IT_BOTH;
        else itype_of = e ? GPP_IT_RISE : GPP_IT_FALL;
    endfunction

    // software data register, masked write
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) data_r <= '0;
        else if (wr && data_hit)
            data_r <= (data_r & ~sel_mask) | (pwdata[7:0] & sel_mask);
    end

    // direction and function select, both reset to software input
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dir_r <= '0;
            afsel_r <= '0;
        end else if (wr) begin
            if (paddr == GPP_DIR_OFF) dir_r <= pwdata[7:0] & pres;
            if (paddr == GPP_AFSEL_OFF) afsel_r <= pwdata[7:0] & pres;
        end
    end

    // interrupt type, enables, pad select and readback index
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sense_r <= '0;
            both_r <= '0;
            event_r <= '0;
            imask_r <= '0;
            padsel_r <= '0;
            idx_r <= '0;
        end else if (wr) begin
            case (paddr)
                GPP_ISENSE_OFF: sense_r <= pwdata[7:0];
                GPP_IBOTH_OFF: both_r <= pwdata[7:0];
                GPP_IEVENT_OFF: event_r <= pwdata[7:0];
                GPP_IMASK_OFF: imask_r <= pwdata[7:0];
                GPP_PADSEL_OFF: padsel_r <= pwdata[7:0];
                GPP_MODE_OFF, GPP_ITYPE_OFF, GPP_PADCFG_OFF:
                    idx_r <= pwdata[10:8];
                default: ;
            endcase
        end
    end

    // condition detection on the synchronised pins
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (sense_r[i])
                hit[i] = (pin_sync[i] == event_r[i]);
            else if (both_r[i])
                hit[i] = pin_sync[i] ^ pin_prev_r[i];
            else
                hit[i] = event_r[i] ? (pin_sync[i] & ~pin_prev_r[i])
                                    : (~pin_sync[i] & pin_prev_r[i]);
        end
        hit = hit & pres & ~dir_r & ~afsel_r;
    end

    assign iclr_set = (wr && paddr == GPP_ICLR_OFF) ? pwdata[7:0] : '0;

    // previous sample and sticky raw status; a new hit beats a clear
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_prev_r <= '0;
            ris_r <= '0;
        end else begin
            pin_prev_r <= pin_sync;
            ris_r <= (ris_r & ~iclr_set) | hit;
        end
    end

    // drive source: peripheral when handed over, else data and direction
    assign drv_d = (afsel_r & periph_o_i) | (~afsel_r & data_r);
    assign drv_e = (afsel_r & periph_oe_i) | (~afsel_r & dir_r);

    // pin drive; an open-drain pin only ever pulls low, never drives high
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_o <= '0;
            pin_oe_o <= '0;
            periph_i_o <= '0;
        end else begin
            pin_o <= drv_d & ~od_vec;
            pin_oe_o <= drv_e & pres & ~(od_vec & drv_d);
            periph_i_o <= pin_sync & afsel_r;
        end
    end

    // pad type decode
    always_comb begin
        for (int i = 0; i < 8; i++)
            od_vec[i] = pad_all[i].ptype inside {GPP_PT_OD, GPP_PT_OD_WPU,
                                                 GPP_PT_OD_WPD};
    end

    // pad ring controls, registered
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            padctl_o <= '0;
            padctl_o.drv2 <= 8'hff;
        end else begin
            for (int i = 0; i < 8; i++) begin
                padctl_o.drv2[i] <= pad_all[i].drive == GPP_DRV_2MA;
                padctl_o.drv4[i] <= pad_all[i].drive == GPP_DRV_4MA;
                padctl_o.drv8[i] <= pad_all[i].drive[1];
                padctl_o.slew[i] <= pad_all[i].drive == GPP_DRV_8MA_SC;
                padctl_o.pull_up[i] <= pad_all[i].ptype inside
                    {GPP_PT_STD_WPU, GPP_PT_OD_WPU};
                padctl_o.pull_dn[i] <= pad_all[i].ptype inside
                    {GPP_PT_STD_WPD, GPP_PT_OD_WPD};
                padctl_o.open_drain[i] <= od_vec[i];
                padctl_o.analog[i] <= pad_all[i].ptype == GPP_PT_ANALOG;
            end
        end
    end

    // interrupt output from enabled status only
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) irq_o <= 1'b0;
        else irq_o <= |((((ris_r & ~iclr_set) | hit)) & imask_r);
    end

    // apb: two cycle access, setup then one access cycle with ready
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= '0;
            if (psel && !penable && !pwrite) begin
                if (data_hit) prdata <= {24'h0, (pin_sync & ~dir_r
                    | data_r & dir_r) & sel_mask};
                else begin
                    case (paddr)
                        GPP_DIR_OFF: prdata <= {24'h0, dir_r};
                        GPP_AFSEL_OFF: prdata <= {24'h0, afsel_r};
                        GPP_ISENSE_OFF: prdata <= {24'h0, sense_r};
                        GPP_IBOTH_OFF: prdata <= {24'h0, both_r};
                        GPP_IEVENT_OFF: prdata <= {24'h0, event_r};
                        GPP_IMASK_OFF: prdata <= {24'h0, imask_r};
                        GPP_RIS_OFF: prdata <= {24'h0, ris_r};
                        GPP_MIS_OFF: prdata <= {24'h0, mis};
                        GPP_PADSEL_OFF: prdata <= {24'h0, padsel_r};
                        GPP_PADCFG_OFF: prdata <= {21'h0, idx_r,
                            3'h0, pad_rd};
                        GPP_MODE_OFF: prdata <= {21'h0, idx_r, 6'h0,
                            mode_of(dir_r[idx_r], afsel_r[idx_r])};
                        GPP_ITYPE_OFF: prdata <= {21'h0, idx_r, 5'h0,
                            itype_of(sense_r[idx_r], both_r[idx_r],
                                     event_r[idx_r])};
                        default: pslverr <= 1'b1;
                    endcase
                end
            end
        end
    end
    assign rd_phase = acc && !pwrite;

    // pready comes exactly one cycle after setup
    property p_ready_timing;
        @(posedge clk_i) disable iff (!rst_n_i)
        (psel && !penable) |=> pready;
    endproperty
    a_ready_timing: assert property (p_ready_timing) else $error("no ready");
    // masked write leaves unselected bits
    property p_masked_write;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr && data_hit) |=> ((data_r & ~$past(sel_mask))
            == ($past(data_r) & ~$past(sel_mask)));
    endproperty
    a_masked_write: assert property (p_masked_write)
        else $error("unselected pin changed");
    property p_write_sets;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr && data_hit) |=> ((data_r & $past(sel_mask))
            == ($past(pwdata[7:0]) & $past(sel_mask)));
    endproperty
    a_write_sets: assert property (p_write_sets)
        else $error("selected pin not written");
    property p_hit_sets;
        @(posedge clk_i) disable iff (!rst_n_i)
        (hit != 0) |=> ((ris_r & $past(hit)) == $past(hit));
    endproperty
    a_hit_sets: assert property (p_hit_sets) else $error("event lost");
    property p_irq;
        @(posedge clk_i) disable iff (!rst_n_i) (mis != 0) |-> ##[0:1] irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");
    property p_irq_masked;
        @(posedge clk_i) disable iff (!rst_n_i) (imask_r == 0) [*2] |-> !irq_o;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("masked irq seen");
    property p_slew_8ma;
        @(posedge clk_i) disable iff (!rst_n_i)
        (padctl_o.slew & ~padctl_o.drv8) == 8'h00;
    endproperty
    a_slew_8ma: assert property (p_slew_8ma) else $error("slew w/o 8ma");
    property p_read_mask;
        @(posedge clk_i) disable iff (!rst_n_i)
        (psel && !penable && !pwrite && data_hit) |=>
            ((prdata[7:0] & ~$past(sel_mask)) == 8'h00);
    endproperty
    a_read_mask: assert property (p_read_mask)
        else $error("unselected pin read");
    c_masked_write: cover property (@(posedge clk_i) wr && data_hit);
    c_irq: cover property (@(posedge clk_i) $rose(irq_o));
    c_handover: cover property (@(posedge clk_i) afsel_r != 0);
    c_rd_phase: cover property (@(posedge clk_i) rd_phase && pready);
endmodule // gpp_port
`default_nettype wire

//--- verilog/gpp_pkg.sv
// gpp_pkg: constants and types shared by the gpio port block
package gpp_pkg;
    localparam int GPP_PINS = 8;
    // register byte offsets
    localparam logic [11:0] GPP_DATA_BASE = 12'h000; // 0x000..0x3fc masked data
    localparam logic [11:0] GPP_DIR_OFF = 12'h400;
    localparam logic [11:0] GPP_AFSEL_OFF = 12'h404;
    localparam logic [11:0] GPP_ISENSE_OFF = 12'h408;
    localparam logic [11:0] GPP_IBOTH_OFF = 12'h40c;
    localparam logic [11:0] GPP_IEVENT_OFF = 12'h410;
    localparam logic [11:0] GPP_IMASK_OFF = 12'h414;
    localparam logic [11:0] GPP_RIS_OFF = 12'h418;
    localparam logic [11:0] GPP_MIS_OFF = 12'h41c;
    localparam logic [11:0] GPP_ICLR_OFF = 12'h420;
    localparam logic [11:0] GPP_PADSEL_OFF = 12'h424;
    localparam logic [11:0] GPP_PADCFG_OFF = 12'h428;
    localparam logic [11:0] GPP_MODE_OFF = 12'h42c;
    localparam logic [11:0] GPP_ITYPE_OFF = 12'h430;
    // data address field holding the pin select mask
    localparam int GPP_MASK_LSB = 2;
    // drive strength codes
    localparam logic [1:0] GPP_DRV_2MA = 2'h0;
    localparam logic [1:0] GPP_DRV_4MA = 2'h1;
    localparam logic [1:0] GPP_DRV_8MA = 2'h2;
    localparam logic [1:0] GPP_DRV_8MA_SC = 2'h3;
    // pad type codes
    localparam logic [2:0] GPP_PT_STD = 3'h0;
    localparam logic [2:0] GPP_PT_STD_WPU = 3'h1;
    localparam logic [2:0] GPP_PT_STD_WPD = 3'h2;
    localparam logic [2:0] GPP_PT_OD = 3'h3;
    localparam logic [2:0] GPP_PT_OD_WPU = 3'h4;
    localparam logic [2:0] GPP_PT_OD_WPD = 3'h5;
    localparam logic [2:0] GPP_PT_ANALOG = 3'h6;
    // control modes read back per pin
    localparam logic [1:0] GPP_MODE_SW_IN = 2'h0;
    localparam logic [1:0] GPP_MODE_SW_OUT = 2'h1;
    localparam logic [1:0] GPP_MODE_HW = 2'h2;
    // interrupt types read back per pin
    localparam logic [2:0] GPP_IT_FALL = 3'h0;
    localparam logic [2:0] GPP_IT_RISE = 3'h1;
    localparam logic [2:0] GPP_IT_BOTH = 3'h2;
    localparam logic [2:0] GPP_IT_LOW = 3'h3;
    localparam logic [2:0] GPP_IT_HIGH = 3'h4;
    // per pin pad setting
    typedef struct packed {
        logic [1:0] drive;
        logic [2:0] ptype;
    } gpp_pad_s;
    localparam gpp_pad_s GPP_PAD_RST = '{drive: 2'h0, ptype: 3'h0};
    // pad controls toward the pad ring
    typedef struct packed {
        logic [7:0] drv2;
        logic [7:0] drv4;
        logic [7:0] drv8;
        logic [7:0] slew;
        logic [7:0] pull_up;
        logic [7:0] pull_dn;
        logic [7:0] open_drain;
        logic [7:0] analog;
    } gpp_padctl_s;
endpackage : gpp_pkg

//--- verilog/gpp_sync.sv
// gpp_sync: two flip-flop synchroniser for the pin inputs
`timescale 1ns/1ps
`default_nettype none
module gpp_sync #(
    parameter int W = 8
) (
    input wire logic clk_i, // system clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic [W-1:0] d_i, // asynchronous input
    output logic [W-1:0] q_o // synchronised output
);
    logic [W-1:0] meta_r;
    // first stage feeds only the second
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= '0;
            q_o <= '0;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule // gpp_sync
`default_nettype wire

//--- verilog/gpp_padmem.sv
// gpp_padmem: per pin pad setting store with registered read
`timescale 1ns/1ps
`default_nettype none
module gpp_padmem
    import gpp_pkg::*;
#(
    parameter int N = 8
) (
    input wire logic clk_i, // system clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic [N-1:0] we_i, // write strobe per pin
    input wire gpp_pkg::gpp_pad_s wdata_i, // setting to write
    input wire logic [2:0] raddr_i, // pin index to read
    output gpp_pkg::gpp_pad_s rdata_o, // registered read data
    output gpp_pkg::gpp_pad_s [N-1:0] all_o // every pin's setting
);
    gpp_pad_s mem_r [N];
    // each selected pin takes the new setting; reset gives 2 mA push-pull
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < N; i++) mem_r[i] <= GPP_PAD_RST;
        end else begin
            for (int i = 0; i < N; i++) if (we_i[i]) mem_r[i] <= wdata_i;
        end
    end
    // registered read port
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) rdata_o <= GPP_PAD_RST;
        else rdata_o <= (32'(raddr_i) < N) ? mem_r[raddr_i] : GPP_PAD_RST;
    end
    always_comb begin
        for (int i = 0; i < N; i++) all_o[i] = mem_r[i];
    end
endmodule // gpp_padmem
`default_nettype wire

//--- sim/gpp_pins_model.sv
// gpp_pins_model: outside circuitry resolving each pin wire level
`timescale 1ns/1ps
`default_nettype none
module gpp_pins_model (
    input wire logic clk_i, // system clock
    input wire logic [7:0] pin_o_i, // port drive levels
    input wire logic [7:0] pin_oe_i, // port drive enables
    input wire logic [7:0] pull_up_i, // weak pull-up per pin
    input wire logic [7:0] pull_dn_i, // weak pull-down per pin
    input wire logic [7:0] ext_val_i, // outside drive levels
    input wire logic [7:0] ext_oe_i, // outside drive enables
    output logic [7:0] level_o // resolved wire levels
);
    logic [7:0] last_r;
    // port drive first, then the outside driver, then the weak pulls
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            if (pin_oe_i[n]) begin
                level_o[n] = pin_o_i[n];
            end else if (ext_oe_i[n]) begin
                level_o[n] = ext_val_i[n];
            end else if (pull_up_i[n]) begin
                level_o[n] = 1'b1;
            end else if (pull_dn_i[n]) begin
                level_o[n] = 1'b0;
            end else begin
                level_o[n] = ~last_r[n]; // floating wire keeps moving
            end
        end
    end
    // previous level, so a floating wire never holds a stale value
    always_ff @(posedge clk_i) begin
        last_r <= level_o;
    end
endmodule // gpp_pins_model
`default_nettype wire

//--- sim/testbench.sv
// testbench: self-checking bench for the gpio port block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import gpp_pkg::*;
    logic clk_i, rst_n_i, psel, penable, pwrite, pready, pslverr, irq_o, ev;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic [7:0] pin_i, pin_o, pin_oe_o, periph_o_i, periph_oe_i, periph_i_o;
    logic [7:0] ext_val, ext_oe;
    gpp_padctl_s padctl_o, pe;
    logic [2:0] codes [5];
    int failures, tests_run;

    gpp_port dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe_o(pin_oe_o), .periph_o_i(periph_o_i),
        .periph_oe_i(periph_oe_i), .periph_i_o(periph_i_o),
        .padctl_o(padctl_o), .irq_o(irq_o));
    gpp_pins_model pins (.clk_i(clk_i), .pin_o_i(pin_o), .pin_oe_i(pin_oe_o),
        .pull_up_i(padctl_o.pull_up), .pull_dn_i(padctl_o.pull_dn),
        .ext_val_i(ext_val), .ext_oe_i(ext_oe), .level_o(pin_i));

    // clock at 200 MHz
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] e,
                       input logic [63:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // one apb transfer: setup, then access until pready
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    function automatic logic [11:0] dat(input logic [7:0] m);
        return {2'b00, m, 2'b00};
    endfunction

    function automatic logic [31:0] cfgw(input logic [2:0] i,
                                         input logic [1:0] dv,
                                         input logic [2:0] pt);
        return {21'h0, i, 3'h0, dv, pt};
    endfunction

    task automatic t_reset();
        pe = '{drv2: 8'hff, default: 8'h00};
        chk("padctl", 64'(pe), 64'(padctl_o));
        chk("pin_oe", 64'h0, 64'(pin_oe_o));
        rd(GPP_DIR_OFF);
        chk("dir", 64'h0, 64'(rv));
        rd(GPP_AFSEL_OFF);
        chk("afsel", 64'h0, 64'(rv));
        $display("test reset done");
    endtask

    task automatic t_irq();
        logic [2:0] cf;
        logic st;
        for (int t = 0; t < 5; t++) begin
            cf = (t == 0) ? 3'b000 : (t == 1) ? 3'b001 : (t == 2) ? 3'b010
                : (t == 3) ? 3'b100 : 3'b101;
            st = (t == 0 || t == 3);
            @(posedge clk_i);
            ext_val <= {7'h0, st};
            cyc(6);
            wr(GPP_ISENSE_OFF, {31'h0, cf[2]});
            wr(GPP_IBOTH_OFF, {31'h0, cf[1]});
            wr(GPP_IEVENT_OFF, {31'h0, cf[0]});
            wr(GPP_IMASK_OFF, {31'h0, t != 0});
            wr(GPP_ITYPE_OFF, 32'(codes[t]));
            wr(GPP_ICLR_OFF, 32'h1);
            rd(GPP_ITYPE_OFF);
            chk("itype", 64'(codes[t]), 64'(rv));
            rd(GPP_RIS_OFF);
            chk("ris idle", 64'h0, 64'(rv));
            @(posedge clk_i);
            ext_val <= {7'h0, ~st};
            cyc(8);
            rd(GPP_RIS_OFF);
            chk("ris hit", 64'h1, 64'(rv));
            rd(GPP_MIS_OFF);
            chk("mis", 64'(t != 0), 64'(rv));
            chk("irq", 64'(t != 0), 64'(irq_o));
            @(posedge clk_i);
            ext_val <= {7'h0, st};
            cyc(8);
            wr(GPP_ICLR_OFF, 32'h1);
            cyc(3);
            rd(GPP_RIS_OFF);
            chk("ris clear", 64'h0, 64'(rv));
            chk("irq clear", 64'h0, 64'(irq_o));
        end
        $display("test interrupts done");
    endtask

    task automatic t_data();
        wr(GPP_DIR_OFF, 32'hff);
        wr(dat(8'h09), 32'hff);
        cyc(2);
        chk("pin_o", 64'h09, 64'(pin_o));
        chk("pin_oe", 64'hff, 64'(pin_oe_o));
        wr(dat(8'hf6), 32'h00);
        cyc(2);
        chk("pin_o kept", 64'h09, 64'(pin_o));
        wr(dat(8'h0c), 32'h04);
        cyc(2);
        chk("pin_o both", 64'h05, 64'(pin_o));
        rd(dat(8'h07));
        chk("data m07", 64'h05, 64'(rv));
        rd(dat(8'h0a));
        chk("data m0a", 64'h00, 64'(rv));
        wr(GPP_DIR_OFF, 32'h0f);
        @(posedge clk_i);
        ext_val <= 8'ha0;
        cyc(4);
        rd(dat(8'hff));
        chk("data mixed", 64'ha5, 64'(rv));
        chk("pin_oe dir", 64'h0f, 64'(pin_oe_o));
        $display("test data done");
    endtask

    task automatic t_mode();
        wr(GPP_AFSEL_OFF, 32'h80);
        @(posedge clk_i);
        periph_o_i <= 8'h80;
        periph_oe_i <= 8'h80;
        cyc(4);
        chk("pin_o hw", 64'h85, 64'(pin_o));
        chk("pin_oe hw", 64'h8f, 64'(pin_oe_o));
        chk("periph_i", 64'h80, 64'(periph_i_o));
        wr(GPP_MODE_OFF, {21'h0, 3'd0, 6'h0, GPP_MODE_SW_OUT});
        rd(GPP_MODE_OFF);
        chk("mode 0", {53'h0, 3'd0, 6'h0, GPP_MODE_SW_OUT}, 64'(rv));
        wr(GPP_MODE_OFF, {21'h0, 3'd4, 6'h0, GPP_MODE_SW_IN});
        rd(GPP_MODE_OFF);
        chk("mode 4", {53'h0, 3'd4, 6'h0, GPP_MODE_SW_IN}, 64'(rv));
        wr(GPP_MODE_OFF, {21'h0, 3'd7, 6'h0, GPP_MODE_HW});
        rd(GPP_MODE_OFF);
        chk("mode 7", {53'h0, 3'd7, 6'h0, GPP_MODE_HW}, 64'(rv));
        wr(GPP_AFSEL_OFF, 32'h0);
        wr(GPP_DIR_OFF, 32'h0);
        $display("test mode done");
    endtask

    task automatic t_pad();
        wr(GPP_PADSEL_OFF, 32'h80);
        wr(GPP_PADCFG_OFF, cfgw(3'd7, GPP_DRV_8MA_SC, GPP_PT_OD_WPU));
        wr(GPP_PADSEL_OFF, 32'h40);
        wr(GPP_PADCFG_OFF, cfgw(3'd6, GPP_DRV_4MA, GPP_PT_ANALOG));
        wr(GPP_PADSEL_OFF, 32'h01);
        wr(GPP_PADCFG_OFF, cfgw(3'd0, GPP_DRV_8MA, GPP_PT_STD_WPD));
        cyc(2);
        pe = '{drv2: 8'h3e, drv4: 8'h40, drv8: 8'h81, slew: 8'h80,
            pull_up: 8'h80, pull_dn: 8'h01, open_drain: 8'h80, analog: 8'h40};
        chk("padctl", 64'(pe), 64'(padctl_o));
        rd(GPP_PADCFG_OFF);
        chk("padcfg 0", 64'(cfgw(3'd0, GPP_DRV_8MA, GPP_PT_STD_WPD)),
            64'(rv));
        // release pins 0 and 7 so only the weak pulls set their level
        @(posedge clk_i);
        ext_val <= 8'h01;
        ext_oe <= 8'h7e;
        cyc(4);
        rd(dat(8'h81));
        chk("data pulls", 64'h80, 64'(rv));
        // open-drain pin 7 pulls low for a zero, lets go for a one
        wr(GPP_DIR_OFF, 32'h80);
        wr(dat(8'h80), 32'h00);
        cyc(2);
        chk("pin_oe od low", 64'h80, 64'(pin_oe_o));
        chk("od level low", 64'h0, 64'(pin_i[7]));
        wr(dat(8'h80), 32'h80);
        cyc(2);
        chk("pin_oe od high", 64'h00, 64'(pin_oe_o));
        chk("od level high", 64'h1, 64'(pin_i[7]));
        wr(GPP_DIR_OFF, 32'h0);
        @(posedge clk_i);
        ext_oe <= 8'hff;
        $display("test pad done");
    endtask

    task automatic t_unmapped();
        rd(12'h800);
        chk("unmapped err", 64'h1, 64'(ev));
        chk("unmapped data", 64'h0, 64'(rv));
        wr(12'h800, 32'hff);
        rd(GPP_DIR_OFF);
        chk("dir kept", 64'h0, 64'(rv));
        chk("dir err", 64'h0, 64'(ev));
        $display("test unmapped done");
    endtask

    // watchdog for a hung bench
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        give_verdict();
    end

    initial begin
        codes = '{GPP_IT_FALL, GPP_IT_RISE, GPP_IT_BOTH, GPP_IT_LOW,
            GPP_IT_HIGH};
        failures = 0;
        tests_run = 0;
        rst_n_i = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        periph_o_i = 8'h00;
        periph_oe_i = 8'h00;
        ext_val = 8'h00;
        ext_oe = 8'hff;
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_irq();
        t_data();
        t_mode();
        t_pad();
        t_unmapped();
        // reset again in mid-run: pad controls, pin enables, direction and function select must return to their defaults
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        cyc(2);
        rst_n_i <= 1'b1;
        t_reset();
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
